// >>> shared/axi_buf_defs.svh
`ifndef AXI_BUF_DEFS_SVH
`define AXI_BUF_DEFS_SVH

// Register byte offsets on the APB side
`define OFS_CTRL       12'h000
`define OFS_MEMSEL     12'h004
`define OFS_STATUS     12'h008
`define OFS_WLEVEL     12'h00c
`define OFS_RLEVEL     12'h010

// Field positions
`define CTRL_MODE_LSB  0
`define CTRL_APP_LSB   10
`define STAT_BUSY_BIT  0
`define STAT_NE_LSB    1
`define STAT_CLK_BIT   6

// Reset values
`define CTRL_RESET     32'h0000_0000
`define MEMSEL_RESET   32'h0000_0000

// Cycles of the clock, less one, that the ready outputs stay low after core reset release
`define RST_WINDOW_CYC 60

// Channel field widths
`define ID_W           4
`define ADDR_W         32
`define LEN_W          8
`define DATA_W         32
`define STRB_W         4
`define RESP_W         2

// Channel depths; packet mode needs room for two longest bursts
`define DEPTH_ADDR     16
`define DEPTH_RESP     16
`define DEPTH_WDATA    512
`define DEPTH_RDATA    512

`endif

// >>> shared/axi_buf_pkg.sv
package axi_buf_pkg;

   // How a channel is built
   typedef enum logic [1:0] {
      mode_fifo,
      mode_slice_full,
      mode_slice_light,
      mode_pass
   } chan_mode_t;

   // What the FIFOs are used for
   typedef enum logic [1:0] {
      app_data,
      app_packet,
      app_low_latency
   } app_t;

endpackage : axi_buf_pkg

// >>> src/axi_channel_buffer.sv
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "axi_buf_defs.svh"

// One channel: FIFO, two-entry slice, one-entry slice or plain wire
module chan_buffer
   import axi_buf_pkg::*;
#(
   parameter int W     = 8,
   parameter int DEPTH = 16,
   parameter int CW    = $clog2(DEPTH + 1),
   parameter int IW    = $clog2(DEPTH)
) (
   input  wire logic          clk,        // Core clock
   input  wire logic          rstn,       // Synchronised core reset, low active
   input  wire chan_mode_t    mode,       // Channel build
   input  wire logic          packet,     // Store-and-forward gating
   input  wire logic          en,         // Low inside the reset window
   input  wire logic          release_ok, // Outside gate on the output side
   input  wire logic          in_valid,   // Input handshake
   output logic               in_ready,   // Input handshake
   input  wire logic [W-1:0]  in_data,    // Input payload
   input  wire logic          in_last,    // Input end of burst
   output logic               out_valid,  // Output handshake
   input  wire logic          out_ready,  // Output handshake
   output logic [W-1:0]       out_data,   // Output payload
   output logic               out_last,   // Output end of burst
   output logic [CW-1:0]      level       // Stored entries
);
   localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

   logic [W:0]    mem [DEPTH];
   logic [IW-1:0] wptr;
   logic [IW-1:0] rptr;
   logic [CW-1:0] cap;
   logic [CW-1:0] next_cnt;
   logic [CW-1:0] last_cnt;
   logic          full_r;
   logic          open_r;
   logic          pass;
   logic          pkt;
   logic          push;
   logic          pop;
   logic          stored_ok;

   // Capacity by build; slices reuse the store with one or two entries
   always_comb begin
      unique case (mode)
         mode_fifo:        cap = DEPTH_C;
         mode_slice_full:  cap = CW'(2);
         mode_slice_light: cap = CW'(1);
         mode_pass:        cap = CW'(1);
      endcase
   end

   assign pass = (mode == mode_pass);
   assign pkt  = packet && (mode == mode_fifo);

   // Ready drops when full or inside the reset window, except in pass mode where it follows out_ready; light slice frees its entry on a pop
   always_comb begin
      if (pass) begin
         in_ready = out_ready;
      end else if (mode == mode_slice_light) begin
         in_ready = en && (!full_r || pop);
      end else begin
         in_ready = en && !full_r;
      end
   end

   // Output released once a whole burst is in, or the store filled first
   assign stored_ok = (level != '0) && release_ok &&
                      (!pkt || (last_cnt != '0) || open_r);
   assign out_valid = pass ? in_valid : stored_ok;
   assign out_data  = pass ? in_data : mem[rptr][W-1:0];
   assign out_last  = pass ? in_last : mem[rptr][W];

   assign push     = !pass && in_valid && in_ready;
   assign pop      = !pass && stored_ok && out_ready;
   assign next_cnt = level + CW'(push) - CW'(pop);

   // Storage write; single entry write port keeps width equal both sides
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wptr] <= {in_last, in_data};
      end
   end

   // Pointers and level; one cycle from push to visible output
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wptr   <= '0;
         rptr   <= '0;
         level  <= '0;
         full_r <= 1'b0;
      end else begin
         if (push) begin
            wptr <= (wptr == IW'(DEPTH - 1)) ? '0 : wptr + IW'(1);
         end
         if (pop) begin
            rptr <= (rptr == IW'(DEPTH - 1)) ? '0 : rptr + IW'(1);
         end
         level  <= next_cnt;
         full_r <= (next_cnt >= cap);
      end
   end

   // Count of stored burst ends, and the overflow-open latch
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         last_cnt <= '0;
         open_r   <= 1'b0;
      end else begin
         last_cnt <= last_cnt + CW'(push && in_last) - CW'(pop && out_last);
         if (push && in_last) begin
            open_r <= 1'b0;
         end else if (pkt && full_r && (last_cnt == '0)) begin
            open_r <= 1'b1;
         end
      end
   end

   a_pass_wire: assert property (@(posedge clk) disable iff (!rstn)
      pass |-> (out_valid == in_valid) && (out_data == in_data))
      else $error("pass-through output differs from input");

   a_full_ready: assert property (@(posedge clk) disable iff (!rstn)
      (mode == mode_fifo) && (level == DEPTH_C) |-> !in_ready)
      else $error("ready high while FIFO full");

   a_empty_valid: assert property (@(posedge clk) disable iff (!rstn)
      !pass && (level == '0) |-> !out_valid)
      else $error("valid high while empty");

   a_pkt_hold: assert property (@(posedge clk) disable iff (!rstn)
      pkt && (last_cnt == '0) && !open_r |-> !out_valid)
      else $error("packet released before its last beat");

   a_slice_lat: assert property (@(posedge clk) disable iff (!rstn)
      (mode == mode_slice_full) && push && (level == '0) && release_ok
      |=> out_valid && (out_data == $past(in_data)))
      else $error("slice did not present data after one cycle");

endmodule : chan_buffer

// AXI memory-mapped buffer with APB configuration
module axi_channel_fifo_wrapper
   import axi_buf_pkg::*;
(
   input  wire logic                pclk,          // Core and APB clock
   input  wire logic                presetn,       // Async reset, low active
   input  wire logic [11:0]         paddr,         // APB address
   input  wire logic                psel,          // APB select
   input  wire logic                penable,       // APB access phase
   input  wire logic                pwrite,        // APB direction
   input  wire logic [31:0]         pwdata,        // APB write data
   output logic [31:0]              prdata,        // APB read data
   output logic                     pready,        // APB ready
   output logic                     pslverr,       // APB error, unmapped
   output logic                     rd_rst_busy,   // Read side in reset
   output logic                     wr_rst_busy,   // Write side in reset
   input  wire logic [`ID_W-1:0]    s_axi_awid,    // AW from upstream
   input  wire logic [`ADDR_W-1:0]  s_axi_awaddr,  // AW address
   input  wire logic [`LEN_W-1:0]   s_axi_awlen,   // AW burst length
   input  wire logic                s_axi_awvalid, // AW valid
   output logic                     s_axi_awready, // AW ready
   output logic [`ID_W-1:0]         m_axi_awid,    // AW to downstream
   output logic [`ADDR_W-1:0]       m_axi_awaddr,  // AW address
   output logic [`LEN_W-1:0]        m_axi_awlen,   // AW burst length
   output logic                     m_axi_awvalid, // AW valid
   input  wire logic                m_axi_awready, // AW ready
   input  wire logic [`DATA_W-1:0]  s_axi_wdata,   // W from upstream
   input  wire logic [`STRB_W-1:0]  s_axi_wstrb,   // W strobes
   input  wire logic                s_axi_wlast,   // W last beat
   input  wire logic                s_axi_wvalid,  // W valid
   output logic                     s_axi_wready,  // W ready
   output logic [`DATA_W-1:0]       m_axi_wdata,   // W to downstream
   output logic [`STRB_W-1:0]       m_axi_wstrb,   // W strobes
   output logic                     m_axi_wlast,   // W last beat
   output logic                     m_axi_wvalid,  // W valid
   input  wire logic                m_axi_wready,  // W ready
   input  wire logic [`ID_W-1:0]    m_axi_bid,     // B from downstream
   input  wire logic [`RESP_W-1:0]  m_axi_bresp,   // B response
   input  wire logic                m_axi_bvalid,  // B valid
   output logic                     m_axi_bready,  // B ready
   output logic [`ID_W-1:0]         s_axi_bid,     // B to upstream
   output logic [`RESP_W-1:0]       s_axi_bresp,   // B response
   output logic                     s_axi_bvalid,  // B valid
   input  wire logic                s_axi_bready,  // B ready
   input  wire logic [`ID_W-1:0]    s_axi_arid,    // AR from upstream
   input  wire logic [`ADDR_W-1:0]  s_axi_araddr,  // AR address
   input  wire logic [`LEN_W-1:0]   s_axi_arlen,   // AR burst length
   input  wire logic                s_axi_arvalid, // AR valid
   output logic                     s_axi_arready, // AR ready
   output logic [`ID_W-1:0]         m_axi_arid,    // AR to downstream
   output logic [`ADDR_W-1:0]       m_axi_araddr,  // AR address
   output logic [`LEN_W-1:0]        m_axi_arlen,   // AR burst length
   output logic                     m_axi_arvalid, // AR valid
   input  wire logic                m_axi_arready, // AR ready
   input  wire logic [`ID_W-1:0]    m_axi_rid,     // R from downstream
   input  wire logic [`DATA_W-1:0]  m_axi_rdata,   // R data
   input  wire logic [`RESP_W-1:0]  m_axi_rresp,   // R response
   input  wire logic                m_axi_rlast,   // R last beat
   input  wire logic                m_axi_rvalid,  // R valid
   output logic                     m_axi_rready,  // R ready
   output logic [`ID_W-1:0]         s_axi_rid,     // R to upstream
   output logic [`DATA_W-1:0]       s_axi_rdata,   // R data
   output logic [`RESP_W-1:0]       s_axi_rresp,   // R response
   output logic                     s_axi_rlast,   // R last beat
   output logic                     s_axi_rvalid,  // R valid
   input  wire logic                s_axi_rready   // R ready
);
   localparam int AW_W = `ID_W + `ADDR_W + `LEN_W;
   localparam int W_W  = `DATA_W + `STRB_W;
   localparam int B_W  = `ID_W + `RESP_W;
   localparam int R_W  = `ID_W + `DATA_W + `RESP_W;
   localparam int LW   = $clog2(`DEPTH_WDATA + 1);

   logic [2:0]      rst_sync;
   logic            core_rstn;
   logic [6:0]      win_cnt;
   logic            busy;
   logic [31:0]     ctrl;
   logic [31:0]     memsel;
   logic [LW-1:0]   w_level;
   logic [LW-1:0]   r_level;
   logic [4:0]      ne;
   logic [LW-1:0]   aw_credit;
   logic [LW:0]     r_rsv;
   logic            pkt_w;
   logic            pkt_r;
   logic            aw_ok;
   logic            ar_ok;
   logic [LW+1:0]   r_need;
   logic            w_last_in;
   logic            aw_out;
   logic            ar_out;
   logic            r_in;
   logic            wr_acc;
   logic            rd_setup;
   app_t            app;
   chan_mode_t      cm [5];

   // Reset: async assert, release after three clean stages
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_sync <= 3'h0;
      end else begin
         rst_sync <= {rst_sync[1:0], 1'b1};
      end
   end
   assign core_rstn = rst_sync[2];

   // Reset window: ready held low a further fixed count after release
   always_ff @(posedge pclk or negedge core_rstn) begin
      if (!core_rstn) begin
         win_cnt     <= 7'h00;
         busy        <= 1'b1;
         rd_rst_busy <= 1'b1;
         wr_rst_busy <= 1'b1;
      end else begin
         if (win_cnt != 7'(`RST_WINDOW_CYC)) begin
            win_cnt <= win_cnt + 7'h01;
         end
         busy        <= (win_cnt != 7'(`RST_WINDOW_CYC));
         rd_rst_busy <= (win_cnt != 7'(`RST_WINDOW_CYC));
         wr_rst_busy <= (win_cnt != 7'(`RST_WINDOW_CYC));
      end
   end

   // Configuration decode; one clock and reset for all channels
   assign app   = app_t'(ctrl[`CTRL_APP_LSB +: 2]);
   assign cm[0] = chan_mode_t'(ctrl[`CTRL_MODE_LSB +: 2]);
   assign cm[1] = chan_mode_t'(ctrl[`CTRL_MODE_LSB + 2 +: 2]);
   assign cm[2] = chan_mode_t'(ctrl[`CTRL_MODE_LSB + 4 +: 2]);
   assign cm[3] = chan_mode_t'(ctrl[`CTRL_MODE_LSB + 6 +: 2]);
   assign cm[4] = chan_mode_t'(ctrl[`CTRL_MODE_LSB + 8 +: 2]);
   assign pkt_w = (app == app_packet) && (cm[1] == mode_fifo);
   assign pkt_r = (app == app_packet) && (cm[4] == mode_fifo);

   // Write packet coupling: credits count only in packet mode, one per burst,
   // so data-mode bursts leave no stale credit to release AW early
   assign w_last_in = s_axi_wvalid && s_axi_wready && s_axi_wlast;
   assign aw_out    = m_axi_awvalid && m_axi_awready;
   assign aw_ok     = !pkt_w || (aw_credit != '0);
   always_ff @(posedge pclk or negedge core_rstn) begin
      if (!core_rstn) begin
         aw_credit <= '0;
      end else begin
         aw_credit <= aw_credit + LW'(w_last_in && pkt_w) - LW'(aw_out && pkt_w);
      end
   end

   // Read packet coupling: reserve room for each forwarded burst
   assign ar_out = m_axi_arvalid && m_axi_arready;
   assign r_in   = m_axi_rvalid && m_axi_rready;
   assign r_need = (LW + 2)'(r_level) + (LW + 2)'(r_rsv) + (LW + 2)'(m_axi_arlen) + 1'b1;
   assign ar_ok  = !pkt_r || (r_need <= (LW + 2)'(`DEPTH_RDATA));
   always_ff @(posedge pclk or negedge core_rstn) begin
      if (!core_rstn) begin
         r_rsv <= '0;
      end else begin
         r_rsv <= r_rsv + (ar_out && pkt_r ? (LW + 1)'(m_axi_arlen) + 1'b1 : '0)
                  - (LW + 1)'(r_in && (r_rsv != '0));
      end
   end

   // Channel buffers: three write side, two read side
   chan_buffer #(.W(AW_W), .DEPTH(`DEPTH_ADDR)) u_aw (
      .clk(pclk), .rstn(core_rstn), .mode(cm[0]), .packet(1'b0), .en(!busy),
      .release_ok(aw_ok), .in_valid(s_axi_awvalid), .in_ready(s_axi_awready),
      .in_data({s_axi_awid, s_axi_awaddr, s_axi_awlen}), .in_last(1'b1),
      .out_valid(m_axi_awvalid), .out_ready(m_axi_awready),
      .out_data({m_axi_awid, m_axi_awaddr, m_axi_awlen}), .out_last(), .level());

   chan_buffer #(.W(W_W), .DEPTH(`DEPTH_WDATA)) u_w (
      .clk(pclk), .rstn(core_rstn), .mode(cm[1]), .packet(pkt_w), .en(!busy),
      .release_ok(1'b1), .in_valid(s_axi_wvalid), .in_ready(s_axi_wready),
      .in_data({s_axi_wdata, s_axi_wstrb}), .in_last(s_axi_wlast),
      .out_valid(m_axi_wvalid), .out_ready(m_axi_wready),
      .out_data({m_axi_wdata, m_axi_wstrb}), .out_last(m_axi_wlast), .level(w_level));

   chan_buffer #(.W(B_W), .DEPTH(`DEPTH_RESP)) u_b (
      .clk(pclk), .rstn(core_rstn), .mode(cm[2]), .packet(1'b0), .en(!busy),
      .release_ok(1'b1), .in_valid(m_axi_bvalid), .in_ready(m_axi_bready),
      .in_data({m_axi_bid, m_axi_bresp}), .in_last(1'b1),
      .out_valid(s_axi_bvalid), .out_ready(s_axi_bready),
      .out_data({s_axi_bid, s_axi_bresp}), .out_last(), .level());

   chan_buffer #(.W(AW_W), .DEPTH(`DEPTH_ADDR)) u_ar (
      .clk(pclk), .rstn(core_rstn), .mode(cm[3]), .packet(1'b0), .en(!busy),
      .release_ok(ar_ok), .in_valid(s_axi_arvalid), .in_ready(s_axi_arready),
      .in_data({s_axi_arid, s_axi_araddr, s_axi_arlen}), .in_last(1'b1),
      .out_valid(m_axi_arvalid), .out_ready(m_axi_arready),
      .out_data({m_axi_arid, m_axi_araddr, m_axi_arlen}), .out_last(), .level());

   chan_buffer #(.W(R_W), .DEPTH(`DEPTH_RDATA)) u_r (
      .clk(pclk), .rstn(core_rstn), .mode(cm[4]), .packet(pkt_r), .en(!busy),
      .release_ok(1'b1), .in_valid(m_axi_rvalid), .in_ready(m_axi_rready),
      .in_data({m_axi_rid, m_axi_rdata, m_axi_rresp}), .in_last(m_axi_rlast),
      .out_valid(s_axi_rvalid), .out_ready(s_axi_rready),
      .out_data({s_axi_rid, s_axi_rdata, s_axi_rresp}), .out_last(s_axi_rlast),
      .level(r_level));

   assign ne = {s_axi_rvalid, m_axi_arvalid, s_axi_bvalid, m_axi_wvalid, m_axi_awvalid};

   // APB: answer in the first access cycle, no wait states
   assign wr_acc   = psel && penable && pready && pwrite;
   assign rd_setup = psel && !penable;
   always_ff @(posedge pclk or negedge core_rstn) begin
      if (!core_rstn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= rd_setup;
         pslverr <= 1'b0;
         if (rd_setup) begin
            prdata <= 32'h0000_0000;
            unique case (paddr)
               `OFS_CTRL:   prdata <= ctrl;
               `OFS_MEMSEL: prdata <= memsel;
               `OFS_STATUS: prdata <= {25'h0, 1'b0, ne, busy};
               `OFS_WLEVEL: prdata <= 32'(w_level);
               `OFS_RLEVEL: prdata <= 32'(r_level);
               default:     pslverr <= 1'b1;
            endcase
         end
      end
   end

   // Writable configuration; change only while the channels are idle
   always_ff @(posedge pclk or negedge core_rstn) begin
      if (!core_rstn) begin
         ctrl   <= `CTRL_RESET;
         memsel <= `MEMSEL_RESET;
      end else if (wr_acc && (paddr == `OFS_CTRL)) begin
         ctrl   <= {20'h0, pwdata[11:0]};
      end else if (wr_acc && (paddr == `OFS_MEMSEL)) begin
         memsel <= {22'h0, pwdata[9:0]};
      end
   end

   a_busy_ready: assert property (@(posedge pclk) disable iff (!presetn)
      busy |-> (cm[0] == mode_pass || !s_axi_awready) && (cm[1] == mode_pass || !s_axi_wready))
      else $error("ready high inside reset window");

   a_rd_busy: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(core_rstn) |-> rd_rst_busy [*8])
      else $error("read reset indicator low right after reset");

   a_aw_hold: assert property (@(posedge pclk) disable iff (!core_rstn)
      pkt_w && (aw_credit == '0) |-> !m_axi_awvalid)
      else $error("AW forwarded before its write data");

   a_ar_room: assert property (@(posedge pclk) disable iff (!core_rstn)
      pkt_r && m_axi_arvalid |-> r_need <= (LW + 2)'(`DEPTH_RDATA))
      else $error("AR forwarded without room for its burst");

endmodule : axi_channel_fifo_wrapper

// >>> testbench/axi_far_slave.sv
`timescale 1ns/1ps
// Downstream slave: random stalls, one B per burst, one-beat reads
module axi_far_slave (
   input  wire logic        pclk,          // Clock
   input  wire logic        presetn,       // Reset
   input  wire logic        m_axi_awvalid, // AW valid
   output logic             m_axi_awready, // AW ready
   input  wire logic        m_axi_wvalid,  // W valid
   input  wire logic        m_axi_wlast,   // W last
   output logic             m_axi_wready,  // W ready
   output logic             m_axi_bvalid,  // B valid
   output logic [3:0]       m_axi_bid,     // B id
   output logic [1:0]       m_axi_bresp,   // B resp
   input  wire logic        m_axi_bready,  // B ready
   input  wire logic        m_axi_arvalid, // AR valid
   output logic             m_axi_arready, // AR ready
   output logic             m_axi_rvalid,  // R valid
   output logic [31:0]      m_axi_rdata,   // R data
   output logic [3:0]       m_axi_rid,     // R id
   output logic [1:0]       m_axi_rresp,   // R resp
   output logic             m_axi_rlast,   // R last
   input  wire logic        m_axi_rready   // R ready
);
   int bpend;
   int rpend;
   int rseq;
   // Valid holds while work is owed; idle data is inverted, not stale
   assign m_axi_bvalid = bpend != 0;
   assign m_axi_rvalid = rpend != 0;
   assign m_axi_rlast = m_axi_rvalid;
   assign m_axi_rdata = m_axi_rvalid ? rseq : ~rseq;
   assign m_axi_bid = 4'h0;
   assign m_axi_rid = 4'h0;
   assign m_axi_bresp = 2'h0;
   assign m_axi_rresp = 2'h0;
   // Stall about one cycle in four, so answers are prompt and slow
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         m_axi_awready <= 1'b0;
         m_axi_wready <= 1'b0;
         m_axi_arready <= 1'b0;
         bpend <= 0;
         rpend <= 0;
         rseq <= 1;
      end else begin
         m_axi_awready <= $urandom_range(0, 3) != 0;
         m_axi_wready <= $urandom_range(0, 3) != 0;
         m_axi_arready <= $urandom_range(0, 3) != 0;
         bpend <= bpend + (m_axi_wvalid && m_axi_wready && m_axi_wlast) - (m_axi_bvalid && m_axi_bready);
         rpend <= rpend + (m_axi_arvalid && m_axi_arready) - (m_axi_rvalid && m_axi_rready);
         rseq <= rseq + (m_axi_rvalid && m_axi_rready);
      end
   end
endmodule : axi_far_slave

// >>> testbench/tb.sv
`timescale 1ns/1ps
module tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
   logic rd_rst_busy, wr_rst_busy, m_axi_bready, s_axi_bvalid, s_axi_bready = 1;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, q, s_axi_awaddr = 0, m_axi_awaddr, s_axi_wdata = 0;
   logic [31:0] m_axi_wdata, s_axi_araddr = 0, m_axi_araddr, m_axi_rdata, s_axi_rdata;
   logic [3:0] s_axi_awid = 0, m_axi_awid, m_axi_bid, s_axi_bid, s_axi_arid = 0, m_axi_arid;
   logic [3:0] m_axi_rid, s_axi_rid, s_axi_wstrb = 0, m_axi_wstrb;
   logic [7:0] s_axi_awlen = 0, m_axi_awlen, s_axi_arlen = 0, m_axi_arlen;
   logic [1:0] m_axi_bresp, s_axi_bresp, m_axi_rresp, s_axi_rresp;
   logic s_axi_awvalid = 0, s_axi_awready, m_axi_awvalid, m_axi_awready, s_axi_wvalid = 0;
   logic s_axi_wlast = 0, s_axi_wready, m_axi_wlast, m_axi_wvalid, m_axi_wready, m_axi_bvalid;
   logic s_axi_arvalid = 0, s_axi_arready, m_axi_arvalid, m_axi_arready, m_axi_rlast;
   logic m_axi_rvalid, m_axi_rready, s_axi_rlast, s_axi_rvalid, s_axi_rready = 1;
   int err_total = 0, checks_done = 0, cyc = 0, k, nb = 0, nw = 0, rn = 0;
   logic [63:0] wq[$], aq[$], rq[$], xq[$];
   axi_channel_fifo_wrapper i_dut (.*);
   axi_far_slave i_far (.*);
   always #10 pclk = ~pclk;
   task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : conclude
   // APB cycle; request held until pready is seen at an edge
   task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      {q, e} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
   endtask : apb
   task automatic drain;
      while (wq.size() + aq.size() + rq.size() + xq.size() > 0 || nb < nw) @(posedge pclk);
   endtask : drain
   // One AW, then n beats back to back; pkt checks the hold-back
   task automatic burst(int n, logic pkt);
      {s_axi_awvalid, s_axi_awaddr, s_axi_awid} <= {1'b1, $urandom, 4'($urandom)};
      s_axi_awlen <= 8'(n - 1);
      do @(posedge pclk); while (s_axi_awready !== 1'b1);
      aq.push_back({s_axi_awid, s_axi_awlen, s_axi_awaddr});
      s_axi_awvalid <= 0;
      for (int i = 0; i < n; i++) begin
         {s_axi_wvalid, s_axi_wdata, s_axi_wstrb} <= {1'b1, $urandom, 4'($urandom)};
         s_axi_wlast <= i == n - 1;
         do @(posedge pclk); while (s_axi_wready !== 1'b1);
         wq.push_back({s_axi_wlast, s_axi_wstrb, s_axi_wdata});
         if (pkt && i < n - 1) chk("held", {m_axi_awvalid, m_axi_wvalid}, 0);
      end
      s_axi_wvalid <= 0;
      nw++;
   endtask : burst
   // n single-beat reads; the far slave answers with a running count
   task automatic rd(int n);
      for (int i = 0; i < n; i++) begin
         {s_axi_arvalid, s_axi_araddr, s_axi_arid} <= {1'b1, $urandom, 4'($urandom)};
         do @(posedge pclk); while (s_axi_arready !== 1'b1);
         xq.push_back({s_axi_arid, s_axi_arlen, s_axi_araddr});
         rn++;
         rq.push_back({1'b1, 6'h00, 32'(rn)});
      end
      s_axi_arvalid <= 0;
   endtask : rd
   // Oldest note against each output handshake except B, which is counted and checked against zero
   always @(posedge pclk) begin
      cyc++;
      s_axi_bready <= $urandom_range(0, 1);
      s_axi_rready <= $urandom_range(0, 1);
      if (m_axi_awvalid && m_axi_awready)
         chk("aw", {m_axi_awid, m_axi_awlen, m_axi_awaddr}, aq.pop_front());
      if (m_axi_wvalid && m_axi_wready)
         chk("w", {m_axi_wlast, m_axi_wstrb, m_axi_wdata}, wq.pop_front());
      if (m_axi_arvalid && m_axi_arready)
         chk("ar", {m_axi_arid, m_axi_arlen, m_axi_araddr}, xq.pop_front());
      if (s_axi_rvalid && s_axi_rready)
         chk("r", {s_axi_rlast, s_axi_rid, s_axi_rresp, s_axi_rdata}, rq.pop_front());
      if (s_axi_bvalid && s_axi_bready) begin
         nb++;
         chk("b", {s_axi_bid, s_axi_bresp}, 0);
      end
      if (cyc == 20000) begin
         err_total++;
         conclude();
      end
   end
   initial begin
      void'($urandom(13));
      repeat (12) @(posedge pclk);
      chk("busy_reset", {rd_rst_busy, wr_rst_busy}, 2'h3);
      presetn <= 1;
      repeat (62) @(posedge pclk);
      chk("window", {rd_rst_busy, wr_rst_busy, s_axi_awready, s_axi_wready}, 4'hc);
      for (k = 0; k < 100 && rd_rst_busy !== 1'b0; k++) @(posedge pclk);
      chk("busy_fell", {rd_rst_busy, wr_rst_busy}, 0);
      apb(0, 12'h000, 0);
      chk("ctrl_reset", q, 0);
      apb(0, 12'h008, 0);
      chk("status", q, 0);
      apb(0, 12'h014, 0);
      chk("unmapped", e, 1);
      apb(1, 12'h004, 32'hffff_ffff);
      apb(0, 12'h004, 0);
      chk("memsel", q, 32'h3ff);
      repeat (4) burst(1 + $urandom_range(0, 7), 0);
      rd(6);
      drain();
      // Packet mode on the W and R buffers, all five channels as FIFOs
      apb(1, 12'h000, 32'h400);
      burst(5, 1);
      rd(2);
      drain();
      apb(1, 12'h000, 32'h3);
      aq.push_back({s_axi_awid, s_axi_awlen, 32'h1234_5678});
      {s_axi_awvalid, s_axi_awaddr} <= {1'b1, 32'h1234_5678};
      do @(posedge pclk); while (s_axi_awready !== 1'b1);
      chk("pass_ready", m_axi_awready, 1);
      s_axi_awvalid <= 0;
      drain();
      // Light AW and AR slices, full W and B slices, R wire, low latency
      apb(1, 12'h000, 32'hb96);
      burst(3, 0);
      rd(3);
      drain();
      chk("bcount", nb, nw);
      conclude();
   end
endmodule : tb
